// ===== hdl/bacr_config_regs.sv
// Button algorithm configuration registers with press, raw-data and interrupt logic
`timescale 1ns/10ps
module bacr_config_regs
  import bacr_pkg::*;
#(
  parameter longint TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic low_power,
  input wire logic [3:0] chan_enable,
  input wire logic [3:0] chan_press,
  input wire logic [3:0] chan_overrange,
  input wire logic capture_done,
  input wire logic [15:0] capture_data,
  input wire logic error_event,
  input wire logic power_wake,
  output logic [3:0] press_out,
  output logic [3:0] timeout_out,
  output logic overrange_flag,
  output logic [15:0] unprocessed_result,
  output logic [3:0] baseline_clear,
  output logic algorithm_clear,
  output logic [2:0] baseline_step,
  output logic [5:0] channel1_gain_field,
  output logic [5:0] channel2_gain_field,
  output logic [5:0] channel3_gain_field,
  output logic [7:0] pause_win,
  output logic irq_pin
);
  logic [7:0] channel1_gain;
  logic [7:0] irq_and_algorithm_control;
  logic [7:0] channel2_gain;
  logic [7:0] sleep_baseline_step;
  logic [7:0] channel3_gain;
  logic [7:0] active_baseline_step;
  logic [7:0] tracking_pause_and_winner_select;
  logic [3:0] held_timeout;
  logic [3:0] press_prev;
  logic irq_event;
  logic irq_active;
  logic [7:0] irq_count;
  bacr_irq_e irq_state;

  wire logic restart_en = irq_and_algorithm_control[BIT_RESTART_EN];
  wire logic press_algorithm_enable = irq_and_algorithm_control[BIT_ALG_EN];
  wire logic irq_polarity_select = irq_and_algorithm_control[BIT_IRQ_POL];
  wire logic press_timeout_disable = irq_and_algorithm_control[BIT_TO_DIS];
  wire logic overrange_check_disable = irq_and_algorithm_control[BIT_OVR_DIS];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = reg_wr && (a == ofs);
  endfunction

  // ==========================================
  // Register writes, reserved bits masked off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      channel1_gain <= RST_GAIN;
      irq_and_algorithm_control <= RST_CTRL;
      channel2_gain <= RST_GAIN;
      sleep_baseline_step <= RST_SLEEP_STEP;
      channel3_gain <= RST_GAIN;
      active_baseline_step <= RST_ACTIVE_STEP;
      tracking_pause_and_winner_select <= RST_PAUSE_WIN;
    end else if (clk_en) begin
      if (hit(reg_addr, OFS_CH1_GAIN)) channel1_gain <= reg_wdata & MASK_GAIN;
      if (hit(reg_addr, OFS_CTRL)) irq_and_algorithm_control <= reg_wdata & MASK_CTRL;
      if (hit(reg_addr, OFS_CH2_GAIN)) channel2_gain <= reg_wdata & MASK_GAIN;
      if (hit(reg_addr, OFS_SLEEP_STEP)) sleep_baseline_step <= reg_wdata & MASK_STEP;
      if (hit(reg_addr, OFS_CH3_GAIN)) channel3_gain <= reg_wdata & MASK_GAIN;
      if (hit(reg_addr, OFS_ACTIVE_STEP)) active_baseline_step <= reg_wdata & MASK_STEP;
      if (hit(reg_addr, OFS_PAUSE_WIN)) begin
        tracking_pause_and_winner_select <= reg_wdata & MASK_PAUSE_WIN;
      end
    end
  end

  // ==========================================
  // Read data, registered; unmapped reads zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (clk_en && reg_rd) begin
      case (reg_addr)
        OFS_CH1_GAIN: reg_rdata <= channel1_gain;
        OFS_CTRL: reg_rdata <= irq_and_algorithm_control;
        OFS_CH2_GAIN: reg_rdata <= channel2_gain;
        OFS_SLEEP_STEP: reg_rdata <= sleep_baseline_step;
        OFS_CH3_GAIN: reg_rdata <= channel3_gain;
        OFS_ACTIVE_STEP: reg_rdata <= active_baseline_step;
        OFS_PAUSE_WIN: reg_rdata <= tracking_pause_and_winner_select;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // Field outputs to the algorithm core
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      channel1_gain_field <= RST_GAIN[5:0];
      channel2_gain_field <= RST_GAIN[5:0];
      channel3_gain_field <= RST_GAIN[5:0];
      baseline_step <= RST_ACTIVE_STEP[2:0];
      pause_win <= RST_PAUSE_WIN;
    end else if (clk_en) begin
      channel1_gain_field <= channel1_gain[5:0];
      channel2_gain_field <= channel2_gain[5:0];
      channel3_gain_field <= channel3_gain[5:0];
      // Step follows the power mode live
      baseline_step <= low_power ? sleep_baseline_step[2:0]
                                 : active_baseline_step[2:0];
      pause_win <= tracking_pause_and_winner_select;
    end
  end

  // ==========================================
  // Wake restart: other state always, baselines only when enabled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      algorithm_clear <= 1'b0;
      baseline_clear <= 4'h0;
    end else if (clk_en) begin
      algorithm_clear <= power_wake;
      baseline_clear <= (power_wake && restart_en) ? chan_enable : 4'h0;
    end
  end

  // ==========================================
  // Press timeout per channel
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_timer
      bacr_press_timer #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_timer (
        .mclk(mclk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pressed(chan_press[g] & chan_enable[g] & press_algorithm_enable),
        .timeout_disable(press_timeout_disable),
        .timed_out(held_timeout[g])
      );
    end
  endgenerate

  // ==========================================
  // Press outputs, over-range and raw data
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      press_out <= 4'h0;
      timeout_out <= 4'h0;
      press_prev <= 4'h0;
      overrange_flag <= 1'b0;
      unprocessed_result <= 16'h0;
    end else if (clk_en) begin
      timeout_out <= held_timeout;
      if (press_algorithm_enable) begin
        press_out <= chan_press & chan_enable & ~held_timeout;
        // Sticky; only a restart clears it, set wins
        if (!overrange_check_disable && |(chan_overrange & chan_enable)) begin
          overrange_flag <= 1'b1;
        end else if (power_wake) begin
          overrange_flag <= 1'b0;
        end
      end else begin
        press_out <= 4'h0;
        if (capture_done) unprocessed_result <= capture_data;
      end
      press_prev <= press_out;
    end
  end

  // ==========================================
  // Interrupt source and pin timing
  always_comb begin
    if (press_algorithm_enable) begin
      irq_event = |(press_out ^ press_prev) | error_event;
    end else begin
      irq_event = capture_done | error_event;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_state <= BACR_IRQ_IDLE;
      irq_count <= 8'h00;
      irq_active <= 1'b0;
    end else if (clk_en) begin
      case (irq_state)
        BACR_IRQ_IDLE: begin
          if (irq_event) begin
            irq_state <= BACR_IRQ_HOLD;
            irq_count <= IRQ_PULSE_CYC;
            irq_active <= 1'b1;
          end
        end
        BACR_IRQ_HOLD: begin
          // A new event restarts the hold so none is lost
          if (irq_event) begin
            irq_count <= IRQ_PULSE_CYC;
          end else if (irq_count == 8'h01) begin
            irq_state <= BACR_IRQ_IDLE;
            irq_active <= 1'b0;
          end else begin
            irq_count <= irq_count - 8'h01;
          end
        end
        default: begin
          irq_state <= BACR_IRQ_IDLE;
          irq_active <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_pin <= 1'b1;
    end else if (clk_en) begin
      irq_pin <= irq_active ^ ~irq_polarity_select;
    end
  end
endmodule // bacr_config_regs

// ===== hdl/bacr_pkg.sv
// Package: register map, field positions, reset values and timing for the config slice
package bacr_pkg;
  localparam logic [7:0] OFS_CH1_GAIN = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h11;
  localparam logic [7:0] OFS_CH2_GAIN = 8'h12;
  localparam logic [7:0] OFS_SLEEP_STEP = 8'h13;
  localparam logic [7:0] OFS_CH3_GAIN = 8'h14;
  localparam logic [7:0] OFS_ACTIVE_STEP = 8'h15;
  localparam logic [7:0] OFS_PAUSE_WIN = 8'h16;
  localparam logic [7:0] RST_GAIN = 8'h28;
  localparam logic [7:0] RST_CTRL = 8'h18;
  localparam logic [7:0] RST_SLEEP_STEP = 8'h05;
  localparam logic [7:0] RST_ACTIVE_STEP = 8'h03;
  localparam logic [7:0] RST_PAUSE_WIN = 8'h00;
  localparam logic [7:0] MASK_GAIN = 8'h3F;
  localparam logic [7:0] MASK_CTRL = 8'h1F;
  localparam logic [7:0] MASK_STEP = 8'h07;
  localparam logic [7:0] MASK_PAUSE_WIN = 8'hFF;
  localparam int BIT_RESTART_EN = 4;
  localparam int BIT_ALG_EN = 3;
  localparam int BIT_IRQ_POL = 2;
  localparam int BIT_TO_DIS = 1;
  localparam int BIT_OVR_DIS = 0;
  localparam int CLK_HZ = 40000000;
  localparam int TIMEOUT_S = 50;
  localparam longint TIMEOUT_CYC = longint'(TIMEOUT_S) * longint'(CLK_HZ);
  localparam logic [7:0] IRQ_PULSE_CYC = 8'h04;
  typedef enum logic [1:0] {
    BACR_IRQ_IDLE = 2'b00,
    BACR_IRQ_HOLD = 2'b01
  } bacr_irq_e;
endpackage

// ===== hdl/bacr_press_timer.sv
// Per-channel press hold timer with 50 s timeout
`timescale 1ns/10ps
module bacr_press_timer
  import bacr_pkg::*;
#(
  parameter longint TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic pressed,
  input wire logic timeout_disable,
  output logic timed_out
);
  logic [31:0] count;

  // ==========================================
  // Hold counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count <= 32'h0;
      timed_out <= 1'b0;
    end else if (clk_en) begin
      if (!pressed) begin
        count <= 32'h0;
        timed_out <= 1'b0;
      end else if (timeout_disable) begin
        count <= 32'h0;
        timed_out <= 1'b0;
      end else if (64'(count) + 64'h1 >= 64'(TIMEOUT_CYCLES)) begin
        timed_out <= 1'b1;
      end else begin
        count <= count + 32'h1;
      end
    end
  end
endmodule // bacr_press_timer

// ===== verif/bacr_config_regs_properties.sv
// Concurrent checks on the configuration register slice ports
`timescale 1ns/10ps
module bacr_config_regs_chk
  import bacr_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] chan_enable,
  input wire logic [3:0] chan_press,
  input wire logic [3:0] chan_overrange,
  input wire logic capture_done,
  input wire logic error_event,
  input wire logic power_wake,
  input wire logic [3:0] press_out,
  input wire logic overrange_flag,
  input wire logic [3:0] baseline_clear,
  input wire logic algorithm_clear,
  input wire logic irq_pin
);
  logic [7:0] ctl;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Shadow of control bits, so checks need no hierarchy
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl <= RST_CTRL;
    end else if (clk_en && reg_wr && reg_addr == OFS_CTRL) begin
      ctl <= reg_wdata & MASK_CTRL;
    end
  end
  AST_UNMAPPED_RD: assert property (
    clk_en && reg_rd && reg_addr > OFS_PAUSE_WIN |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CTRL_RSVD: assert property (
    clk_en && reg_rd && reg_addr == OFS_CTRL |=> reg_rdata[7:5] == 3'h0)
    else $error("control reserved bits read back");
  AST_PRESS_OFF: assert property (
    clk_en && !ctl[3] |=> press_out == 4'h0)
    else $error("press output while algorithm off");
  AST_PRESS_ON: assert property (
    clk_en && ctl[3] |=> (press_out & ~$past(chan_press & chan_enable)) == 4'h0)
    else $error("press output without press");
  AST_IRQ_RAW: assert property (
    clk_en && !ctl[3] && (capture_done || error_event) |-> ##[1:3] irq_pin == ctl[2])
    else $error("no irq after capture or error");
  AST_WAKE: assert property (
    clk_en && power_wake |=> algorithm_clear
      && baseline_clear == ($past(ctl[4]) ? $past(chan_enable) : 4'h0))
    else $error("wake clear pulses wrong");
  AST_OVR_SET: assert property (
    clk_en && ctl[3] && !ctl[0] && (chan_overrange & chan_enable) != 4'h0 |=> overrange_flag)
    else $error("over-range flag not set");
  AST_OVR_DIS: assert property (
    clk_en && ctl[0] && !overrange_flag |=> !overrange_flag)
    else $error("over-range flag set while disabled");
endmodule // bacr_config_regs_chk
bind bacr_config_regs bacr_config_regs_chk i_bacr_config_regs_chk (
  .mclk(mclk),
  .resetn(resetn),
  .clk_en(clk_en),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .chan_enable(chan_enable),
  .chan_press(chan_press),
  .chan_overrange(chan_overrange),
  .capture_done(capture_done),
  .error_event(error_event),
  .power_wake(power_wake),
  .press_out(press_out),
  .overrange_flag(overrange_flag),
  .baseline_clear(baseline_clear),
  .algorithm_clear(algorithm_clear),
  .irq_pin(irq_pin)
);

// ===== verif/bacr_sensor_model.sv
// Capture front end model delivering finished conversions
`timescale 1ns/10ps
module bacr_sensor_model #(
  parameter int LAT = 3
) (
  input wire logic mclk,
  input wire logic start,
  input wire logic [15:0] value,
  output logic capture_done,
  output logic [15:0] capture_data
);
  int cnt = 0;
  initial capture_done = 1'b0;
  initial capture_data = 16'h0000;
  // Data toggles outside the done cycle, so a late sample shows
  always @(posedge mclk) begin
    if (start) cnt = LAT;
    else if (cnt > 0) cnt = cnt - 1;
    #1;
    capture_done = (cnt == 1);
    capture_data = capture_done ? value : ~capture_data;
  end
endmodule // bacr_sensor_model

// ===== verif/test_bacr_config_regs.sv
// Testbench for the button algorithm configuration registers
`timescale 1ns/10ps
module test_bacr_config_regs
  import bacr_pkg::*;
;
  logic mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, low_power = 1'b0;
  logic error_event = 1'b0, power_wake = 1'b0, start = 1'b0;
  logic capture_done, irq_pin, overrange_flag, algorithm_clear;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] chan_enable = 4'hF, chan_press = 4'h0, chan_overrange = 4'h0;
  logic [3:0] press_out, timeout_out, baseline_clear;
  logic [15:0] capture_data, unprocessed_result;
  logic [2:0] baseline_step;
  logic [5:0] g1, g2, g3;
  logic [7:0] pause_win;
  logic clk_en = 1'b1;
  logic [7:0] rst [8] = '{8'h28, 8'h18, 8'h28, 8'h05, 8'h28, 8'h03, 8'h00, 8'h00};
  int errors = 0, compares = 0;
  bacr_config_regs #(.TIMEOUT_CYCLES(20)) i_bacr_config_regs (
    .mclk(mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .low_power(low_power),
    .chan_enable(chan_enable),
    .chan_press(chan_press),
    .chan_overrange(chan_overrange),
    .capture_done(capture_done),
    .capture_data(capture_data),
    .error_event(error_event),
    .power_wake(power_wake),
    .press_out(press_out),
    .timeout_out(timeout_out),
    .overrange_flag(overrange_flag),
    .unprocessed_result(unprocessed_result),
    .baseline_clear(baseline_clear),
    .algorithm_clear(algorithm_clear),
    .baseline_step(baseline_step),
    .channel1_gain_field(g1),
    .channel2_gain_field(g2),
    .channel3_gain_field(g3),
    .pause_win(pause_win),
    .irq_pin(irq_pin)
  );
  bacr_sensor_model i_bacr_sensor_model (.mclk(mclk), .start(start), .value(16'h1234),
    .capture_done(capture_done), .capture_data(capture_data));
  initial forever #12.5 mclk = ~mclk;
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    end_sim();
  end
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk("reg_rdata", 16'(exp), 16'(reg_rdata));
    tick(1);
  endtask
  task automatic wirq(logic e);
    for (int i = 0; i < 20 && irq_pin !== e; i++) tick(1);
    chk("irq_pin", 16'(e), 16'(irq_pin));
  endtask
  task automatic pulse_wake();
    power_wake = 1'b1;
    tick(1);
    power_wake = 1'b0;
  endtask
  task automatic end_sim();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    tick(20);
    resetn = 1'b1;
    foreach (rst[i]) rd(8'h10 + 8'(i), rst[i]);
    chk("channel1_gain", 16'h0028, 16'(g1));
    // Enable low must drop the write and freeze the field copy
    clk_en = 1'b0;
    wr(OFS_CH3_GAIN, 8'h11);
    chk("channel3_gain", 16'h0028, 16'(g3));
    clk_en = 1'b1;
    rd(OFS_CH3_GAIN, 8'h28);
    wr(OFS_CH1_GAIN, 8'hC5);
    wr(OFS_CH3_GAIN, 8'h7A);
    chk("channel1_gain", 16'h0005, 16'(g1));
    chk("channel3_gain", 16'h003A, 16'(g3));
    wr(OFS_PAUSE_WIN, 8'hA5);
    chk("pause_win", 16'h00A5, 16'(pause_win));
    wr(OFS_CTRL, 8'hFF);
    rd(OFS_CTRL, 8'h1F);
    wr(OFS_CTRL, 8'h18);
    wr(OFS_CH2_GAIN, 8'hFF);
    chk("channel2_gain", 16'h003F, 16'(g2));
    wr(OFS_SLEEP_STEP, 8'hFE);
    low_power = 1'b1;
    tick(2);
    chk("baseline_step", 16'h0006, 16'(baseline_step));
    wr(OFS_ACTIVE_STEP, 8'h02);
    low_power = 1'b0;
    tick(2);
    chk("baseline_step", 16'h0002, 16'(baseline_step));
    chan_press = 4'h5;
    tick(2);
    chk("press_out", 16'h0005, 16'(press_out));
    wirq(1'b0);
    wr(OFS_CTRL, 8'h10);
    tick(10);
    wirq(1'b1);
    chan_press = 4'hA;
    repeat (6) begin
      tick(1);
      chk("irq_pin", 16'h0001, 16'(irq_pin));
    end
    chk("press_out", 16'h0000, 16'(press_out));
    chan_press = 4'h0;
    wr(OFS_CTRL, 8'h04);
    wirq(1'b0);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    wirq(1'b1);
    chk("unprocessed_result", 16'h1234, unprocessed_result);
    wirq(1'b0);
    error_event = 1'b1;
    tick(1);
    error_event = 1'b0;
    wirq(1'b1);
    wr(OFS_CTRL, 8'h18);
    chan_press = 4'h1;
    tick(30);
    chk("timeout_out", 16'h0001, 16'(timeout_out));
    chk("press_out", 16'h0000, 16'(press_out));
    chan_press = 4'h0;
    wr(OFS_CTRL, 8'h1A);
    chan_press = 4'h1;
    tick(30);
    chk("timeout_out", 16'h0000, 16'(timeout_out));
    chk("press_out", 16'h0001, 16'(press_out));
    chan_press = 4'h0;
    wr(OFS_CTRL, 8'h18);
    chan_overrange = 4'h2;
    tick(1);
    chan_overrange = 4'h0;
    tick(1);
    chk("overrange_flag", 16'h0001, 16'(overrange_flag));
    chan_enable = 4'h5;
    pulse_wake();
    chk("baseline_clear", 16'h0005, 16'(baseline_clear));
    tick(1);
    chk("overrange_flag", 16'h0000, 16'(overrange_flag));
    // Set and wake clear in one cycle: set wins
    chan_overrange = 4'h1;
    pulse_wake();
    chan_overrange = 4'h0;
    chk("overrange_flag", 16'h0001, 16'(overrange_flag));
    pulse_wake();
    chk("overrange_flag", 16'h0000, 16'(overrange_flag));
    wr(OFS_CTRL, 8'h09);
    chan_overrange = 4'h1;
    tick(1);
    chan_overrange = 4'h0;
    tick(1);
    chk("overrange_flag", 16'h0000, 16'(overrange_flag));
    pulse_wake();
    chk("baseline_clear", 16'h0000, 16'(baseline_clear));
    chk("algorithm_clear", 16'h0001, 16'(algorithm_clear));
    end_sim();
  end
endmodule // test_bacr_config_regs
